// ===== ssx_params.svh
`ifndef SSX_PARAMS_SVH
`define SSX_PARAMS_SVH
// opcode encodings on the req.op field
`define SSX_OP_NOP      4'h0
`define SSX_OP_SWAP     4'h1
`define SSX_OP_SWAPW    4'h2
`define SSX_OP_SKZ      4'h3
`define SSX_OP_CPSKZ    4'h4
`define SSX_OP_BSKZ     4'h5
`define SSX_OP_TRDC     4'h6
`define SSX_OP_TRDL     4'h7
`define SSX_OP_XORW     4'h8
`define SSX_OP_XOR_TO_MEM 4'h9
`define SSX_OP_XORI     4'ha
// reset values
`define SSX_ACC_RST     8'h00
`define SSX_ZF_RST      1'b0
`define SSX_HI_LATCH_RST 6'h00
// program memory: 11-bit word address, 8-bit page offset
`define SSX_PAGE_HI     3
`define SSX_LAST_PAGE   3'h7
// field positions of a program word
`define SSX_WORD_LO_MSB 7
`define SSX_WORD_HI_LSB 8
// cycles for a taken skip
`define SSX_SKIP_CYC    2
`endif

// ===== ssx_pkg.sv
package ssx_pkg;
  typedef enum logic [1:0] {
    SSX_RUN   = 2'b00,
    SSX_DUMMY = 2'b01
  } ssx_state_t;

  typedef struct packed {
    logic [3:0]  op;
    logic [7:0]  mem;
    logic [2:0]  bit_sel;
    logic [7:0]  imm;
  } ssx_req_t;

  typedef struct packed {
    ssx_state_t  st;
    logic [7:0]  acc;
    logic        zf;
    logic [5:0]  hi_latch;
    logic        mem_we;
    logic [7:0]  mem_wdata;
    logic        flush;
    logic        busy;
    logic        rom_re;
    logic [10:0] rom_addr;
    logic        trd_pend;
  } ssx_regs_t;
endpackage : ssx_pkg

// ===== ssx_exec.sv
`timescale 1ns/1ps
`include "ssx_params.svh"
// What this block does
// RULE1 - swap in place exchanges memory byte nibbles, writes back, flags kept
// RULE2 - swap to working loads swapped nibbles into working register only
// RULE3 - byte zero test skips next instruction in two cycles, else one
// RULE4 - taken skip discards prefetched instruction and inserts a dummy cycle
// RULE5 - copy and zero skip loads working register, skips when byte zero
// RULE6 - bit zero test skips next instruction when selected bit is zero
// RULE7 - current page table read: low byte to memory, high to latch
// RULE8 - last page table read: low byte to memory, high to latch
// RULE9 - xor with memory result goes to working register, zero flag only
// RULE10 - xor to memory result goes to memory byte, zero flag only
// RULE11 - xor immediate result goes to working register, zero flag only
// RULE12 - zero flag set exactly when the eight-bit result is zero
module ssx_exec (
  input  wire logic            core_clk,
  input  wire logic            srst,
  input  wire ssx_pkg::ssx_req_t req,
  input  wire logic            req_valid,
  input  wire logic [10:0]     pc,
  input  wire logic [7:0]      table_pointer,
  input  wire logic [13:0]     rom_word,
  output logic [7:0]           acc,
  output logic                 zero_flag,
  output logic [5:0]           table_high_latch,
  output logic                 mem_we,
  output logic [7:0]           mem_wdata,
  output logic                 flush,
  output logic                 busy,
  output logic                 rom_re,
  output logic [10:0]          rom_addr
);
  // ==========================================================
  // helpers
  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    nib_swap = {v[3:0], v[7:4]};
  endfunction : nib_swap

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  ssx_pkg::ssx_regs_t s_r;
  ssx_pkg::ssx_regs_t s_nxt;
  logic [7:0]         xr;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt           = s_r;
    s_nxt.mem_we    = 1'b0;
    s_nxt.flush     = 1'b0;
    s_nxt.rom_re    = 1'b0;
    s_nxt.mem_wdata = s_r.mem_wdata;
    xr              = s_r.acc ^ req.mem;
    // table word arrives on the cycle after the fetch
    if (s_r.trd_pend) begin
      // table word lands: memory gets low byte, latch the high part
      s_nxt.mem_we    = 1'b1;                           // see RULE7
      s_nxt.mem_wdata = rom_word[`SSX_WORD_LO_MSB:0];   // see RULE8
      s_nxt.hi_latch  = rom_word[13:`SSX_WORD_HI_LSB];
      s_nxt.busy      = 1'b0;
    end
    unique case (s_r.st)
      ssx_pkg::SSX_DUMMY: begin
        // dummy cycle replaces the discarded prefetch
        s_nxt.st   = ssx_pkg::SSX_RUN;                  // see RULE4
        s_nxt.busy = 1'b0;
      end
      ssx_pkg::SSX_RUN: begin
        if (req_valid && !s_r.busy) begin
          unique case (req.op)
            `SSX_OP_SWAP: begin
              s_nxt.mem_we    = 1'b1;                   // see RULE1
              s_nxt.mem_wdata = nib_swap(req.mem);
            end
            `SSX_OP_SWAPW: s_nxt.acc = nib_swap(req.mem); // see RULE2
            `SSX_OP_SKZ, `SSX_OP_CPSKZ, `SSX_OP_BSKZ: begin
              if (req.op == `SSX_OP_CPSKZ)
                s_nxt.acc = req.mem;                    // see RULE5
              if ((req.op == `SSX_OP_BSKZ) ? !req.mem[req.bit_sel]
                  : is_zero(req.mem)) begin             // see RULE3
                s_nxt.flush = 1'b1;                     // see RULE6
                s_nxt.busy  = 1'b1;
                s_nxt.st    = ssx_pkg::SSX_DUMMY;       // see RULE4
              end
            end
            `SSX_OP_TRDC, `SSX_OP_TRDL: begin
              s_nxt.rom_re   = 1'b1;
              s_nxt.busy     = 1'b1;
              s_nxt.rom_addr = {(req.op == `SSX_OP_TRDL) ? `SSX_LAST_PAGE
                                : pc[10:8], table_pointer}; // see RULE7
            end
            `SSX_OP_XORW: begin
              s_nxt.acc = xr;                           // see RULE9
              s_nxt.zf  = is_zero(xr);                  // see RULE12
            end
            `SSX_OP_XOR_TO_MEM: begin
              s_nxt.mem_we    = 1'b1;                   // see RULE10
              s_nxt.mem_wdata = xr;
              s_nxt.zf        = is_zero(xr);            // see RULE12
            end
            `SSX_OP_XORI: begin
              s_nxt.acc = s_r.acc ^ req.imm;            // see RULE11
              s_nxt.zf  = is_zero(s_r.acc ^ req.imm);   // see RULE12
            end
            default: ;
          endcase
        end
      end
      default: s_nxt.st = ssx_pkg::SSX_RUN;
    endcase
    s_nxt.trd_pend = s_nxt.rom_re;
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r.st        <= ssx_pkg::SSX_RUN;
      s_r.acc       <= `SSX_ACC_RST;
      s_r.zf        <= `SSX_ZF_RST;
      s_r.hi_latch  <= `SSX_HI_LATCH_RST;
      s_r.mem_we    <= 1'b0;
      s_r.mem_wdata <= 8'h00;
      s_r.flush     <= 1'b0;
      s_r.busy      <= 1'b0;
      s_r.rom_re    <= 1'b0;
      s_r.rom_addr  <= 11'h000;
      s_r.trd_pend  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign acc              = s_r.acc;
  assign zero_flag        = s_r.zf;
  assign table_high_latch = s_r.hi_latch;
  assign mem_we           = s_r.mem_we;
  assign mem_wdata        = s_r.mem_wdata;
  assign flush            = s_r.flush;
  assign busy             = s_r.busy;
  assign rom_re           = s_r.rom_re;
  assign rom_addr         = s_r.rom_addr;

  // ==========================================================
  // checks
  logic take;
  assign take = req_valid && !s_r.busy && s_r.st == ssx_pkg::SSX_RUN;

  sequence s_skip_req;
    take && (req.op == `SSX_OP_SKZ) && req.mem == 8'h00;
  endsequence
  sequence s_dummy;
    flush && busy ##1 !busy;
  endsequence

  a_skip_byte_zero: assert property (@(posedge core_clk) disable iff (srst)
    s_skip_req |=> s_dummy) else $error("byte skip missing"); // see RULE3
  a_skip_dummy_cyc: assert property (@(posedge core_clk) disable iff (srst)
    flush |-> s_r.st == ssx_pkg::SSX_DUMMY ##1 s_r.st == ssx_pkg::SSX_RUN)
    else $error("dummy cycle wrong"); // see RULE4
  a_noskip_nonzero: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_SKZ && req.mem != 8'h00 |=> !flush)
    else $error("spurious skip"); // see RULE3
  a_bit_skip: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_BSKZ |=> flush == !$past(req.mem[req.bit_sel]))
    else $error("bit skip wrong"); // see RULE6
  a_swap_inplace: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_SWAP |=> mem_we &&
    mem_wdata == {$past(req.mem[3:0]), $past(req.mem[7:4])} && $stable(zero_flag))
    else $error("swap in place wrong"); // see RULE1
  a_swap_working: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_SWAPW |=> !mem_we &&
    acc == {$past(req.mem[3:0]), $past(req.mem[7:4])})
    else $error("swap to acc wrong"); // see RULE2
  a_copy_skip: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_CPSKZ |=> acc == $past(req.mem) &&
    flush == ($past(req.mem) == 8'h00)) else $error("copy skip wrong"); // see RULE5
  a_table_last: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_TRDL |=> rom_re && rom_addr[10:8] == 3'h7
    ##1 mem_we && mem_wdata == $past(rom_word[7:0]))
    else $error("last page read wrong"); // see RULE8
  a_table_cur: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_TRDC |=> rom_addr == {$past(pc[10:8]),
    $past(table_pointer)} ##1 table_high_latch == $past(rom_word[13:8]))
    else $error("current page read wrong"); // see RULE7
  a_xor_acc: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_XORW |=> acc == ($past(acc) ^ $past(req.mem))
    && zero_flag == (acc == 8'h00)) else $error("xor acc wrong"); // see RULE9
  a_xor_mem: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_XOR_TO_MEM |=> mem_we && $stable(acc) &&
    zero_flag == (mem_wdata == 8'h00)) else $error("xor mem wrong"); // see RULE10
  a_xor_imm: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_XORI |=> acc == ($past(acc) ^ $past(req.imm))
    && zero_flag == (acc == 8'h00)) else $error("xor imm wrong"); // see RULE11

  // ==========================================================
  // flag and side-effect checks
  // a table fetch holds busy for one cycle, then lands the word
  sequence s_table_fetch;
    rom_re && busy ##1 mem_we && !busy;
  endsequence

  a_swapw_flags: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_SWAPW |=> $stable(zero_flag) && !flush)
    else $error("swap to acc touched flags"); // see RULE2
  a_skip_flags: assert property (@(posedge core_clk) disable iff (srst)
    take && (req.op == `SSX_OP_SKZ || req.op == `SSX_OP_BSKZ)
    |=> $stable(zero_flag) && $stable(acc) && !mem_we)
    else $error("skip test touched state"); // see RULE3
  a_copy_flags: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_CPSKZ |=> $stable(zero_flag) && !mem_we)
    else $error("copy skip touched flags"); // see RULE5
  a_flush_pulse: assert property (@(posedge core_clk) disable iff (srst)
    flush |=> !flush)
    else $error("flush longer than one cycle"); // see RULE4
  a_table_seq: assert property (@(posedge core_clk) disable iff (srst)
    take && (req.op == `SSX_OP_TRDC || req.op == `SSX_OP_TRDL)
    |=> s_table_fetch)
    else $error("table fetch sequence wrong"); // see RULE7
  a_table_flags: assert property (@(posedge core_clk) disable iff (srst)
    take && (req.op == `SSX_OP_TRDC || req.op == `SSX_OP_TRDL)
    |=> $stable(zero_flag) ##1 $stable(zero_flag) && $stable(acc))
    else $error("table read touched flags"); // see RULE7
  a_table_latch: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_TRDL
    |=> ##1 table_high_latch == $past(rom_word[13:8]))
    else $error("last page latch wrong"); // see RULE8
  a_xor_imm_mem: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_XORI |=> !mem_we && !flush)
    else $error("xor imm wrote memory"); // see RULE11
  a_xor_mem_val: assert property (@(posedge core_clk) disable iff (srst)
    take && req.op == `SSX_OP_XOR_TO_MEM
    |=> mem_wdata == ($past(acc) ^ $past(req.mem)))
    else $error("xor mem value wrong"); // see RULE10
endmodule : ssx_exec

// ===== ssx_exec_bench.sv
`timescale 1ns/1ps
`include "ssx_params.svh"
module ssx_exec_bench;
  // ==========================================
  // signals
  logic              core_clk;
  logic              srst;
  ssx_pkg::ssx_req_t req;
  logic              req_valid;
  logic [10:0]       pc;
  logic [7:0]        table_pointer;
  logic [13:0]       rom_word;
  logic [7:0]        acc;
  logic              zero_flag;
  logic [5:0]        table_high_latch;
  logic              mem_we;
  logic [7:0]        mem_wdata;
  logic              flush;
  logic              busy;
  logic              rom_re;
  logic [10:0]       rom_addr;
  int                n_mismatch;
  int                comparisons;
  int                cyc;

  ssx_exec u_dut (
    .core_clk(core_clk), .srst(srst), .req(req), .req_valid(req_valid),
    .pc(pc), .table_pointer(table_pointer), .rom_word(rom_word),
    .acc(acc), .zero_flag(zero_flag), .table_high_latch(table_high_latch),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .flush(flush), .busy(busy),
    .rom_re(rom_re), .rom_addr(rom_addr));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // returns 1 ns after the taken edge, with outputs settled
  task automatic send(input logic [3:0] op, input logic [7:0] m,
                      input logic [2:0] b, input logic [7:0] imm);
    @(posedge core_clk);
    req       <= '{op: op, mem: m, bit_sel: b, imm: imm};
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
  endtask : send

  task automatic skp(input logic [3:0] op, input logic [7:0] m,
                     input logic [2:0] b, input logic exp);
    send(op, m, b, 8'h00);
    chk(flush, exp);
    chk(busy, exp);
    chk(mem_we, 1'b0);
    if (exp) begin
      @(posedge core_clk);
      #1;
      chk({flush, busy}, 2'h0);
    end
  endtask : skp

  task automatic tbl(input logic [3:0] op, input logic [2:0] pg,
                     input logic [13:0] w);
    rom_word <= w;
    send(op, 8'h00, 3'h0, 8'h00);
    chk(rom_re, 1'b1);
    chk(rom_addr, {pg, table_pointer});
    @(posedge core_clk);
    #1;
    chk(mem_we, 1'b1);
    chk(mem_wdata, w[7:0]);
    chk(table_high_latch, w[13:8]);
    chk({busy, rom_re, zero_flag}, 3'h1);
  endtask : tbl

  // ==========================================
  // scenarios
  task automatic t_xor;
    send(`SSX_OP_XORI, 8'h00, 3'h0, 8'h5a);
    chk({acc, 7'h0, zero_flag}, 16'h5a00);
    send(`SSX_OP_XORI, 8'h00, 3'h0, 8'h5a);
    chk({acc, 7'h0, zero_flag}, 16'h0001);
    send(`SSX_OP_XORW, 8'h3c, 3'h0, 8'hff);
    chk({acc, 6'h0, mem_we, zero_flag}, 16'h3c00);
    send(`SSX_OP_XOR_TO_MEM, 8'h0f, 3'h0, 8'h00);
    chk({mem_wdata, acc}, 16'h333c);
    chk({mem_we, zero_flag}, 2'h2);
    send(`SSX_OP_XOR_TO_MEM, 8'h3c, 3'h0, 8'h00);
    chk({mem_we, zero_flag, mem_wdata}, 10'h300);
    $display("test xor done");
  endtask : t_xor

  task automatic t_swap;
    send(`SSX_OP_SWAP, 8'ha5, 3'h0, 8'h00);
    chk({mem_we, zero_flag, mem_wdata}, 10'h35a);
    chk(acc, 8'h3c);
    send(`SSX_OP_SWAPW, 8'h12, 3'h0, 8'h00);
    chk({acc, 6'h0, mem_we, zero_flag}, 16'h2101);
    $display("test swap done");
  endtask : t_swap

  task automatic t_skip;
    skp(`SSX_OP_SKZ, 8'h00, 3'h0, 1'b1);
    skp(`SSX_OP_SKZ, 8'h01, 3'h0, 1'b0);
    skp(`SSX_OP_CPSKZ, 8'h00, 3'h0, 1'b1);
    chk(acc, 8'h00);
    skp(`SSX_OP_CPSKZ, 8'h80, 3'h0, 1'b0);
    chk({acc, 7'h0, zero_flag}, 16'h8001);
    skp(`SSX_OP_BSKZ, 8'hf7, 3'h3, 1'b1);
    skp(`SSX_OP_BSKZ, 8'h08, 3'h3, 1'b0);
    skp(`SSX_OP_BSKZ, 8'h7f, 3'h7, 1'b1);
    skp(`SSX_OP_BSKZ, 8'hfe, 3'h0, 1'b1);
    $display("test skip done");
  endtask : t_skip

  // ==========================================
  // main sequence
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    srst = 1'b1;
    req = '0;
    req_valid = 1'b0;
    pc = 11'h3a5;
    table_pointer = 8'h44;
    rom_word = 14'h0000;
    repeat (8) @(posedge core_clk);
    #1;
    chk({acc, zero_flag, table_high_latch, busy, flush}, 17'h0);
    @(posedge core_clk);
    srst <= 1'b0;
    t_xor();
    t_swap();
    t_skip();
    tbl(`SSX_OP_TRDC, 3'h3, 14'h2b6c);
    tbl(`SSX_OP_TRDL, 3'h7, 14'h15a3);
    $display("test table done");
    close_out();
  end
endmodule : ssx_exec_bench
